// *** include/scm_pkg.sv ***
// constants, register map and mode type of the system clock controller
package scm_pkg;
    // bus and clock
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam longint CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    // register byte offsets
    localparam logic [7:0] ADDR_CLKCTL = 8'h00;
    localparam logic [7:0] ADDR_HCTL = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    // system clock control fields
    localparam int CLKCTL_SEL_LSB = 5;
    localparam int CLKCTL_HS_KEEP_BIT = 1;
    localparam int CLKCTL_LS_KEEP_BIT = 0;
    // high speed oscillator control fields
    localparam int HCTL_FREQ_LSB = 2;
    localparam int HCTL_STABLE_BIT = 1;
    localparam int HCTL_EN_BIT = 0;
    // reset values
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic KEEP_RST = 1'b0;
    localparam logic HS_EN_RST = 1'b1;
    localparam logic [1:0] FREQ_RST = 2'h0;
    // selector code that picks the low speed source
    localparam logic [2:0] SEL_SUB = 3'h7;
    // frequency select codes
    localparam logic [1:0] FREQ_4M = 2'h1;
    localparam logic [1:0] FREQ_8M = 2'h2;
    // oscillator rates turned into phase increments of a 16 bit accumulator
    localparam int ACC_W = 16;
    localparam longint HS_2M_HZ = 2_000_000;
    localparam longint HS_4M_HZ = 4_000_000;
    localparam longint HS_8M_HZ = 8_000_000;
    localparam longint LS_HZ = 32_000;
    localparam logic [15:0] INC_2M = 16'((HS_2M_HZ << ACC_W) / CLK_HZ);
    localparam logic [15:0] INC_4M = 16'((HS_4M_HZ << ACC_W) / CLK_HZ);
    localparam logic [15:0] INC_8M = 16'((HS_8M_HZ << ACC_W) / CLK_HZ);
    localparam logic [15:0] INC_LS = 16'((LS_HZ << ACC_W) / CLK_HZ);
    // divider depth: f_H down to f_H/64
    localparam int DIV_W = 6;
    localparam int NUM_TAPS = 7;
    // oscillator settling time, rounded up to whole cycles
    localparam int HS_SETTLE_NS = 16000;
    localparam int HS_SETTLE_CYC = (HS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // operating modes
    typedef enum logic [2:0] {
        MD_FAST,
        MD_SLOW,
        MD_SLEEP,
        MD_IDLE_LOWSPEED_ONLY,
        MD_IDLE_BOTH_CLOCKS,
        MD_IDLE_HIGHSPEED_ONLY,
        MD_WAKE
    } scm_mode_t;
endpackage

// *** include/scm_clk_if.sv ***
// tick and selection signals between controller and system clock switch
`timescale 1ns/1ns
interface scm_clk_if;
    logic hs_tick; // high speed oscillator tick
    logic ls_tick; // low speed oscillator tick
    logic hs_run; // high speed oscillator running and live
    logic ls_run; // low speed oscillator running
    logic [2:0] sel; // requested selector code
    logic [2:0] sel_active; // selector code in force
    logic sys_tick; // system clock tick before mode gating
    logic [6:0] hs_taps; // f_H .. f_H/64 ticks
    modport mux (input hs_tick, ls_tick, hs_run, ls_run, sel,
                 output sys_tick, hs_taps, sel_active);
    modport ctl (input hs_tick, ls_tick, sys_tick, hs_taps, sel_active,
                 output hs_run, ls_run, sel);
endinterface

// *** verilog/scm_nco.sv ***
// phase accumulator that stands in for an rc oscillator as a tick stream
`timescale 1ns/1ns
module scm_nco #(
    parameter int W = 16
) (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // control
    input logic run,
    input logic [W-1:0] inc,
    // one-cycle tick at the oscillator rate
    output logic tick
);
    logic [W-1:0] acc_q; // phase
    logic [W:0] sum; // phase plus carry

    // too narrow an accumulator cannot resolve the slow source
    if (W < 8) begin : g_chk
        $error("scm_nco: W must be at least 8");
    end

    assign sum = {1'b0, acc_q} + {1'b0, inc};

    // a stopped oscillator restarts from phase zero
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            acc_q <= '0;
            tick <= 1'b0;
        end else begin
            acc_q <= sum[W-1:0];
            tick <= sum[W];
        end
    end
endmodule

// *** verilog/scm_sysclk_mux.sv ***
// divider taps and glitch-free system clock source switch
`timescale 1ns/1ns
module scm_sysclk_mux (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // ticks in, selected tick out
    scm_clk_if.mux ck
);
    import scm_pkg::*;

    logic [DIV_W-1:0] div_q; // counts high speed ticks
    logic [NUM_TAPS-1:0] taps; // divided ticks
    logic [2:0] sel_q; // selector code in force
    logic cur_tick; // tick of the source in force
    logic cur_run; // source in force is running

    // tap k fires once every 2^k high speed ticks
    for (genvar k = 0; k < NUM_TAPS; k++) begin : g_tap
        localparam logic [DIV_W-1:0] MSK = DIV_W'((1 << k) - 1);
        assign taps[k] = ck.hs_tick & ((div_q & MSK) == MSK);
    end

    assign cur_tick = (sel_q == SEL_SUB) ? ck.ls_tick : taps[sel_q];
    assign cur_run = (sel_q == SEL_SUB) ? ck.ls_run : ck.hs_run;

    // divider counter, cleared while the oscillator is off
    always_ff @(posedge aclk) begin
        if (!aresetn || !ck.hs_run) begin
            div_q <= '0;
        end else if (ck.hs_tick) begin
            div_q <= div_q + 1'b1;
        end
    end

    // change over only at the end of a whole period of the old source,
    // or at once if that source has stopped and can give no more edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_q <= SEL_RST;
        end else if (ck.sel != sel_q && (cur_tick || !cur_run)) begin
            sel_q <= ck.sel;
        end
    end

    // registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ck.sys_tick <= 1'b0;
            ck.hs_taps <= '0;
        end else begin
            ck.sys_tick <= cur_tick;
            ck.hs_taps <= taps;
        end
    end

    assign ck.sel_active = sel_q;
endmodule

// *** verilog/scm_clock_ctrl.sv ***
// system clock and power mode controller with an axi4-lite register slave
//
// Operation
// - selector 111 picks the low-speed source
// - codes 000-110 divide f_H by 1..64
// - f_SUB from 32 kHz rc, f_H 2/4/8 MHz
// - f_H kept for peripherals per enable bit
// - six modes; halt alone enters the stopped ones
// - fast: cpu and all clocks run
// - slow: cpu on f_SUB, f_H per enable
// - halt, both keep bits 0: sleep, all stop
// - sleep keeps 32 kHz only with watchdog
// - halt, ls keep only: f_SUB stays on
// - halt, both keep bits: cpu stops only
// - halt, hs keep only: f_H stays on
// - freq field 00/01/10/11 gives 2/4/8/2 MHz
// - stable flag clears, sets; then new frequency
// - reset: selector 000, keeps 0, oscillator on
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module scm_clock_ctrl (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // axi4-lite write address
    input logic awvalid,
    output logic awready,
    input logic [scm_pkg::ADDR_W-1:0] awaddr,
    input logic [2:0] awprot,
    // axi4-lite write data
    input logic wvalid,
    output logic wready,
    input logic [scm_pkg::DATA_W-1:0] wdata,
    input logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input logic arvalid,
    output logic arready,
    input logic [scm_pkg::ADDR_W-1:0] araddr,
    input logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input logic rready,
    output logic [scm_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // cpu and watchdog, same clock domain
    input logic halt_req,
    input logic wake_req,
    input logic watchdog_function,
    // clock ticks and status
    output logic cpu_clk_tick,
    output logic system_clock_tick,
    output logic [6:0] hs_periph_tick,
    output logic sub_clk_tick,
    output logic ls_rc_tick,
    output logic hs_osc_on,
    output logic halted
);
    import scm_pkg::*;

    scm_clk_if ck(); // ticks between oscillators, switch and controller

    // software controls
    logic [2:0] sysclk_source_select_q; // selector
    logic hs_osc_idle_keep_q; // keep f_H on after halt
    logic ls_osc_idle_keep_q; // keep f_SUB on after halt
    logic hs_osc_enable_q; // oscillator enable
    logic [1:0] hs_osc_freq_select_q; // requested frequency
    logic [1:0] freq_act_q; // frequency in force
    // oscillator state
    logic hs_osc_stable_flag_q; // read-only stable flag
    logic hs_live_q; // oscillator gives ticks
    logic [$clog2(HS_SETTLE_CYC+1)-1:0] settle_q; // settling count
    logic hs_on_q; // oscillator powered
    logic hs_on_d;
    logic hs_restart; // new settling period starts
    logic [15:0] hs_inc; // phase step of the frequency in force
    // mode
    scm_mode_t mode_q, mode_d;
    scm_mode_t run_tgt; // mode the selector asks for
    logic sys_on, sub_on, ls_rc_on, cpu_run;
    // bus
    logic aw_hold_q, w_hold_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [DATA_W-1:0] w_data_q;
    logic w_strb0_q;
    logic wr_do; // both halves held, response free
    logic [ADDR_W-1:0] wa, ra; // word aligned addresses
    logic wr_clkctl, wr_hctl;
    logic [DATA_W-1:0] rd_val;
    logic rd_hit;

    // ---------------- axi4-lite slave ----------------
    assign wr_do = aw_hold_q && w_hold_q && !bvalid;
    assign wa = {aw_addr_q[ADDR_W-1:2], 2'b00};
    assign ra = {araddr[ADDR_W-1:2], 2'b00};
    assign wr_clkctl = wr_do && w_strb0_q && (wa == ADDR_CLKCTL);
    assign wr_hctl = wr_do && w_strb0_q && (wa == ADDR_HCTL);

    // address and data are taken in either order and held until the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            awready <= 1'b1;
            aw_addr_q <= '0;
        end else if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            awready <= 1'b0;
            aw_addr_q <= awaddr;
        end else if (bvalid && bready) begin
            aw_hold_q <= 1'b0;
            awready <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_q <= 1'b0;
            wready <= 1'b1;
            w_data_q <= '0;
            w_strb0_q <= 1'b0;
        end else if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            wready <= 1'b0;
            w_data_q <= wdata;
            w_strb0_q <= wstrb[0];
        end else if (bvalid && bready) begin
            w_hold_q <= 1'b0;
            wready <= 1'b1;
        end
    end

    // write response; writes to the status word are ignored but answered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid <= 1'b1;
            bresp <= (wa == ADDR_CLKCTL || wa == ADDR_HCTL || wa == ADDR_STAT)
                     ? RESP_OKAY : RESP_DECERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read mux; unused bits read as zero
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (ra)
            ADDR_CLKCTL: begin
                rd_val[CLKCTL_SEL_LSB +: 3] = sysclk_source_select_q;
                rd_val[CLKCTL_HS_KEEP_BIT] = hs_osc_idle_keep_q;
                rd_val[CLKCTL_LS_KEEP_BIT] = ls_osc_idle_keep_q;
            end
            ADDR_HCTL: begin
                rd_val[HCTL_FREQ_LSB +: 2] = hs_osc_freq_select_q;
                rd_val[HCTL_STABLE_BIT] = hs_osc_stable_flag_q;
                rd_val[HCTL_EN_BIT] = hs_osc_enable_q;
            end
            ADDR_STAT: begin
                rd_val[2:0] = mode_q;
                rd_val[3] = cpu_run;
                rd_val[4] = sys_on;
                rd_val[5] = hs_on_q;
                rd_val[6] = sub_on;
                rd_val[7] = ls_rc_on;
                rd_val[10:8] = ck.sel_active;
            end
            default: begin
                rd_hit = 1'b0; // unmapped
            end
        endcase
    end

    // read channel, one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
        end
    end

    // ---------------- control registers ----------------
    // selector may change at any time; the switch picks it up safely
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sysclk_source_select_q <= SEL_RST;
            hs_osc_idle_keep_q <= KEEP_RST;
            ls_osc_idle_keep_q <= KEEP_RST;
        end else if (wr_clkctl) begin
            sysclk_source_select_q <= w_data_q[CLKCTL_SEL_LSB +: 3];
            hs_osc_idle_keep_q <= w_data_q[CLKCTL_HS_KEEP_BIT];
            ls_osc_idle_keep_q <= w_data_q[CLKCTL_LS_KEEP_BIT];
        end
    end

    // oscillator enable and frequency request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_osc_enable_q <= HS_EN_RST;
            hs_osc_freq_select_q <= FREQ_RST;
        end else if (wr_hctl) begin
            hs_osc_enable_q <= w_data_q[HCTL_EN_BIT];
            hs_osc_freq_select_q <= w_data_q[HCTL_FREQ_LSB +: 2];
        end
    end

    // enabling the oscillator or asking for a new frequency restarts settling
    assign hs_restart = wr_hctl && ((w_data_q[HCTL_EN_BIT] && !hs_osc_enable_q)
        || (w_data_q[HCTL_FREQ_LSB +: 2] != hs_osc_freq_select_q));

    // ---------------- high speed oscillator ----------------
    // power: fast, both idles that keep f_H, slow per the enable bit
    always_comb begin
        case (mode_q)
            MD_FAST: hs_on_d = 1'b1;
            MD_SLOW: hs_on_d = hs_osc_enable_q;
            MD_IDLE_BOTH_CLOCKS: hs_on_d = 1'b1;
            MD_IDLE_HIGHSPEED_ONLY: hs_on_d = 1'b1;
            MD_WAKE: hs_on_d = (run_tgt == MD_FAST) || hs_osc_enable_q;
            default: hs_on_d = 1'b0;
        endcase
    end

    // settling: flag drops at start, rises after the settling time, and only
    // then is the requested frequency put into force; until then a running
    // oscillator keeps its old rate so the system clock never jumps mid-way
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_on_q <= 1'b0;
            settle_q <= '0;
            hs_osc_stable_flag_q <= 1'b0;
            hs_live_q <= 1'b0;
            freq_act_q <= FREQ_RST;
        end else begin
            hs_on_q <= hs_on_d;
            if (!hs_on_d) begin
                settle_q <= '0;
                hs_osc_stable_flag_q <= 1'b0;
                hs_live_q <= 1'b0;
            end else if (!hs_on_q || hs_restart) begin
                settle_q <= '0;
                hs_osc_stable_flag_q <= 1'b0;
            end else if (!hs_osc_stable_flag_q) begin
                if (settle_q == ($bits(settle_q))'(HS_SETTLE_CYC - 1)) begin
                    hs_osc_stable_flag_q <= 1'b1;
                    hs_live_q <= 1'b1;
                    freq_act_q <= hs_osc_freq_select_q;
                end else begin
                    settle_q <= settle_q + 1'b1;
                end
            end
        end
    end

    // frequency code to phase step; code 11 falls back to 2 MHz
    always_comb begin
        case (freq_act_q)
            FREQ_4M: hs_inc = INC_4M;
            FREQ_8M: hs_inc = INC_8M;
            default: hs_inc = INC_2M;
        endcase
    end

    assign ck.hs_run = hs_on_q && hs_live_q;
    assign ck.ls_run = ls_rc_on;
    assign ck.sel = sysclk_source_select_q;

    // the two rc sources
    scm_nco #(.W(ACC_W)) u_hs_osc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ck.hs_run),
        .inc(hs_inc),
        .tick(ck.hs_tick)
    );
    scm_nco #(.W(ACC_W)) u_ls_osc (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(ck.ls_run),
        .inc(INC_LS),
        .tick(ck.ls_tick)
    );

    // divider taps and safe source switch
    scm_sysclk_mux u_mux (
        .aclk(aclk),
        .aresetn(aresetn),
        .ck(ck)
    );

    // ---------------- operating mode ----------------
    assign run_tgt = (sysclk_source_select_q == SEL_SUB) ? MD_SLOW : MD_FAST;

    // stopped modes come only from halt; wake goes through a restart state
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MD_FAST, MD_SLOW: begin
                if (halt_req) begin
                    case ({hs_osc_idle_keep_q, ls_osc_idle_keep_q})
                        2'b00: mode_d = MD_SLEEP;
                        2'b01: mode_d = MD_IDLE_LOWSPEED_ONLY;
                        2'b11: mode_d = MD_IDLE_BOTH_CLOCKS;
                        default: mode_d = MD_IDLE_HIGHSPEED_ONLY;
                    endcase
                end else if (run_tgt != mode_q) begin
                    // fast needs a live oscillator first
                    mode_d = (run_tgt == MD_FAST && !hs_live_q) ? MD_WAKE : run_tgt;
                end
            end
            MD_WAKE: begin
                if (run_tgt == MD_SLOW || hs_live_q) begin
                    mode_d = run_tgt;
                end
            end
            MD_SLEEP, MD_IDLE_LOWSPEED_ONLY, MD_IDLE_BOTH_CLOCKS,
            MD_IDLE_HIGHSPEED_ONLY: begin
                if (wake_req) begin
                    mode_d = MD_WAKE;
                end
            end
            default: mode_d = MD_FAST;
        endcase
    end

    // mode register; comes out of reset in fast with the selector at 000
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= MD_FAST;
        end else begin
            mode_q <= mode_d;
        end
    end

    // clock gates per mode
    always_comb begin
        cpu_run = (mode_q == MD_FAST) || (mode_q == MD_SLOW);
        ls_rc_on = (mode_q == MD_SLEEP) ? watchdog_function : 1'b1;
        case (mode_q)
            MD_FAST, MD_SLOW: begin
                sys_on = 1'b1;
                sub_on = 1'b1;
            end
            MD_IDLE_LOWSPEED_ONLY: begin
                sys_on = (sysclk_source_select_q == SEL_SUB);
                sub_on = 1'b1;
            end
            MD_IDLE_BOTH_CLOCKS: begin
                sys_on = 1'b1;
                sub_on = 1'b1;
            end
            MD_IDLE_HIGHSPEED_ONLY: begin
                sys_on = (sysclk_source_select_q != SEL_SUB);
                sub_on = 1'b0;
            end
            MD_WAKE: begin
                sys_on = 1'b0; // clock held until the source is ready
                sub_on = 1'b1;
            end
            default: begin
                sys_on = 1'b0;
                sub_on = 1'b0;
            end
        endcase
    end

    // registered clock ticks and status pins; taps still in the pipeline when
    // the oscillator powers down are dropped, so no late tick follows power-off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_clk_tick <= 1'b0;
            system_clock_tick <= 1'b0;
            hs_periph_tick <= '0;
            sub_clk_tick <= 1'b0;
            ls_rc_tick <= 1'b0;
            hs_osc_on <= 1'b0;
            halted <= 1'b0;
        end else begin
            cpu_clk_tick <= ck.sys_tick && sys_on && cpu_run;
            system_clock_tick <= ck.sys_tick && sys_on;
            hs_periph_tick <= ck.hs_taps & {NUM_TAPS{hs_on_q}};
            sub_clk_tick <= ck.ls_tick && sub_on;
            ls_rc_tick <= ck.ls_tick;
            hs_osc_on <= hs_on_q;
            halted <= !cpu_run && (mode_q != MD_WAKE);
        end
    end
endmodule

// *** verif/scm_clock_ctrl_sva.sv ***
// assertion checker for the system clock controller ports
`timescale 1ns/1ns
module scm_clock_ctrl_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // mode pins
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic halted,
    // clock ticks and oscillator status
    input wire logic cpu_clk_tick,
    input wire logic system_clock_tick,
    input wire logic sub_clk_tick,
    input wire logic ls_rc_tick,
    input wire logic hs_osc_on,
    input wire logic [6:0] hs_periph_tick
);
    // cycles since reset, saturating so it never wraps back under the settle figure
    logic [7:0] up_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) up_q <= 8'h0;
        else if (up_q != 8'hff) up_q <= up_q + 8'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sys_settle_a: assert property (system_clock_tick |-> up_q >= 8'ha0)
        else $error("system clock ticked before oscillator settled");
    osc_boot_a: assert property ($rose(aresetn) |-> ##[1:2] hs_osc_on)
        else $error("oscillator not enabled after reset");
    periph_live_a: assert property ((|hs_periph_tick) |-> hs_osc_on)
        else $error("peripheral tap ticks with oscillator off");
    tap_nest_a: assert property (hs_periph_tick[1] |-> hs_periph_tick[0])
        else $error("divided tap not aligned to base tick");
    cpu_run_a: assert property (cpu_clk_tick |-> system_clock_tick && !halted)
        else $error("cpu ticked without system clock or while halted");
    halt_cause_a: assert property ($rose(halted) |-> $past(halt_req, 2) || $past(halt_req, 3))
        else $error("halt mode entered without halt request");
    sub_src_a: assert property (sub_clk_tick |-> ls_rc_tick)
        else $error("low speed clock without its source");
    halt_hold_a: assert property (halted && !wake_req && !$past(wake_req) |=> halted)
        else $error("halt mode left without wake");
    cover property ($rose(halted));
    cover property (halted && sub_clk_tick);
    cover property ($fell(halted));
endmodule
bind scm_clock_ctrl scm_clock_ctrl_sva chk_i (.aclk, .aresetn, .halt_req, .wake_req, .halted,
    .cpu_clk_tick, .system_clock_tick, .sub_clk_tick, .ls_rc_tick, .hs_osc_on, .hs_periph_tick);

// *** verif/system_clock_and_power_modes_test.sv ***
// self-checking bench for the system clock and power mode controller
`timescale 1ns/1ns
module system_clock_and_power_modes_test;
    import scm_pkg::*;
    // bench-driven inputs
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, halt_req = 1'b0, wake_req = 1'b0;
    logic watchdog_function = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rd;
    // design outputs
    logic awready, wready, bvalid, arready, rvalid, cpu_clk_tick, system_clock_tick;
    logic sub_clk_tick, ls_rc_tick, hs_osc_on, halted;
    logic [1:0] bresp, rresp, rr;
    logic [31:0] rdata;
    logic [6:0] hs_periph_tick;
    int fail_count = 0, total_checks = 0;
    always #50 aclk = ~aclk;
    scm_clock_ctrl uut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
        .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .halt_req, .wake_req,
        .watchdog_function, .cpu_clk_tick, .system_clock_tick, .hs_periph_tick,
        .sub_clk_tick, .ls_rc_tick, .hs_osc_on, .halted);
    task automatic final_report();
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // each transfer starts one edge late so no signal is assigned twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            n++;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, RESP_OKAY});
        if (n == 50) chk(32'h0, 32'h1);
        if (n == 50) final_report();
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            n++;
        end while (!rvalid && n < 50);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
        if (n == 50) chk(32'h0, 32'h1);
        if (n == 50) final_report();
    endtask
    // read until masked value matches, bounded since settling takes many cycles
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        int n = 0;
        do begin
            rd_reg(a);
            n++;
        end while ((rd & m) !== e && n < 400);
        chk(rd & m, e);
        if ((rd & m) !== e) final_report();
    endtask
    task automatic count(input int k, input int cyc, output int s, output int t);
        s = 0;
        t = 0;
        repeat (cyc) begin
            @(posedge aclk);
            s += int'(system_clock_tick);
            t += int'(hs_periph_tick[k]);
        end
    endtask
    task automatic t_reset();
        rd_reg(ADDR_CLKCTL);
        chk(rd, 32'h0);
        rd_reg(ADDR_HCTL);
        chk(rd, 32'h1);
        rd_reg(8'h0c);
        chk({rd[29:0], rr}, {30'h0, RESP_DECERR});
        poll(ADDR_HCTL, 32'h2, 32'h2);
        poll(ADDR_STAT, 32'h7ff, 32'hf8);
    endtask
    // every frequency code; the last returns to the reset rate
    task automatic t_freq();
        int e[4] = '{400, 800, 200, 200};
        int s, t;
        for (int f = 1; f < 5; f++) begin
            wr(ADDR_HCTL, {28'h0, 2'(f), 2'h1});
            if (f == 1) rd_reg(ADDR_HCTL);
            if (f == 1) chk(rd & 32'h2, 32'h0);
            poll(ADDR_HCTL, 32'h2, 32'h2);
            count(0, 1000, s, t);
            chk(32'(t >= e[f-1] - 3 && t <= e[f-1] + 3), 32'h1);
        end
    endtask
    task automatic t_div();
        int s, t;
        for (int k = 0; k < 7; k++) begin
            wr(ADDR_CLKCTL, 32'(k) << 5);
            repeat (400) @(posedge aclk);
            count(k, 1300, s, t);
            chk(32'(s > 0 && s - t <= 1 && t - s <= 1), 32'h1);
            chk(32'(t >= (260 >> k) - 1 && t <= (260 >> k) + 1), 32'h1);
        end
    endtask
    task automatic t_slow();
        wr(ADDR_CLKCTL, 32'he0);
        poll(ADDR_STAT, 32'h707, 32'h701);
        wr(ADDR_HCTL, 32'h0);
        poll(ADDR_STAT, 32'h20, 32'h0);
        wr(ADDR_HCTL, 32'h1);
        wr(ADDR_CLKCTL, 32'h0);
        poll(ADDR_STAT, 32'h7ff, 32'hf8);
    endtask
    // keep codes 00,01,10,11 then sleep with the watchdog on
    task automatic t_halt();
        logic [7:0] ex[5] = '{8'h02, 8'hc3, 8'hb5, 8'hf4, 8'h82};
        int s, t;
        for (int i = 0; i < 5; i++) begin
            watchdog_function <= (i == 4);
            wr(ADDR_CLKCTL, 32'(i % 4));
            @(posedge aclk);
            halt_req <= 1'b1;
            @(posedge aclk);
            halt_req <= 1'b0;
            poll(ADDR_STAT, 32'hff, {24'h0, ex[i]});
            count(0, 400, s, t);
            chk(32'(s > 0), 32'(ex[i][4]));
            chk(32'(t > 0), 32'(ex[i][5]));
            chk({30'h0, halted, hs_osc_on}, {30'h0, 1'b1, ex[i][5]});
            @(posedge aclk);
            wake_req <= 1'b1;
            @(posedge aclk);
            wake_req <= 1'b0;
            poll(ADDR_STAT, 32'hff, 32'hf8);
            chk({31'h0, halted}, 32'h0);
        end
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_freq();
        t_div();
        t_slow();
        t_halt();
        final_report();
    end
endmodule
